// File: logic/zarc_pkg.sv
/*
 * constants, register map and state encoding for the two-zone
 * accumulate and release controller.
 * assumes a 125 MHz sys_clk and 16-bit registers on a 32-bit bus.
 */
// Functional notes
// - new release value frees carton, holds next
// - release during full downstream waits, then fires
// - counters differ while carton occupies zone
// - departure makes departure count equal arrival
// - hold bit set stops arriving cartons
// - hold bit cleared frees carton, no hold
// - tracking applies only via release; cancel discards
// - arrival presents carton tracking words
// - downstream zone repeats same mechanism separately
// - induct status four runs upstream zone
// - induct words valid after four-to-one, captured
// - status four at arrival means long carton
// - discharged zone waits confirmation, holds newcomers
// - both words all-ones clear; single word stored
// - missing confirmation reports a jam
package zarc_pkg;
	// ----------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------
	localparam logic [7:0] UP_BASE      = 8'h00;
	localparam logic [7:0] DN_BASE      = 8'h40;
	localparam logic [7:0] OFS_ACC      = 8'h00;
	localparam logic [7:0] OFS_REL      = 8'h04;
	localparam logic [7:0] OFS_REL_CUR  = 8'h08;
	localparam logic [7:0] OFS_ARR      = 8'h0C;
	localparam logic [7:0] OFS_DEP      = 8'h10;
	localparam logic [7:0] OFS_STRK1    = 8'h14;
	localparam logic [7:0] OFS_STRK2    = 8'h18;
	localparam logic [7:0] OFS_CTRK1    = 8'h1C;
	localparam logic [7:0] OFS_CTRK2    = 8'h20;
	localparam logic [7:0] ADR_IND_STAT = 8'h80;
	localparam logic [7:0] ADR_IND_TRK1 = 8'h84;
	localparam logic [7:0] ADR_IND_TRK2 = 8'h88;
	localparam logic [7:0] ADR_IRQ_STAT = 8'h8C;
	localparam logic [7:0] ADR_IRQ_CLR  = 8'h90;
	localparam logic [7:0] ADR_IRQ_EN   = 8'h94;
	// ----------------------------------------------------------
	// fields and values
	// ----------------------------------------------------------
	localparam int unsigned ACC_HOLD_BIT = 0;
	localparam logic [15:0] REG_RESET    = 16'h0000;
	localparam logic [15:0] TRK_CLEAR    = 16'hFFFF;
	localparam logic [15:0] TRK_KEEP     = 16'h0000;
	localparam logic [15:0] IND_RUN      = 16'h0004;
	localparam logic [15:0] IND_VALID    = 16'h0001;
	localparam int unsigned IRQ_W        = 7;
	localparam int unsigned IRQ_UP_ARR   = 0;
	localparam int unsigned IRQ_UP_DEP   = 1;
	localparam int unsigned IRQ_DN_ARR   = 2;
	localparam int unsigned IRQ_DN_DEP   = 3;
	localparam int unsigned IRQ_UP_JAM   = 4;
	localparam int unsigned IRQ_DN_JAM   = 5;
	localparam int unsigned IRQ_LONG     = 6;
	// ----------------------------------------------------------
	// timing
	// ----------------------------------------------------------
	localparam int unsigned CLK_HZ       = 125_000_000;
	localparam int unsigned JAM_TIME_MS  = 2000;
	localparam int unsigned JAM_CYCLES   = JAM_TIME_MS * (CLK_HZ / 1000);
	// ----------------------------------------------------------
	// zone states
	// ----------------------------------------------------------
	typedef enum logic [2:0] {
		ZS_EMPTY = 3'b001,
		ZS_HELD  = 3'b010,
		ZS_DISCH = 3'b100
	} zarc_state_e;
endpackage

// File: logic/zarc_zone.sv
/*
 * one conveyor zone: counts, hold, release, tracking, confirmation.
 * assumes sensor and confirm are synchronous to sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module zarc_zone #(
	parameter int unsigned JAM_CYC = zarc_pkg::JAM_CYCLES
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// field
	input  wire logic        sensor,
	input  wire logic        ds_clear,
	input  wire logic        wake,
	input  wire logic        confirm,
	output logic             motor_run,
	output logic             ready,
	// control
	input  wire logic        acc_hold,
	input  wire logic        rel_we,
	input  wire logic [15:0] rel_val,
	input  wire logic [15:0] set_trk1,
	input  wire logic [15:0] set_trk2,
	input  wire logic [15:0] in_trk1,
	input  wire logic [15:0] in_trk2,
	// status
	output logic [15:0]      arr_cnt_q,
	output logic [15:0]      dep_cnt_q,
	output logic [15:0]      rel_cnt_q,
	output logic [15:0]      trk1_q,
	output logic [15:0]      trk2_q,
	output logic             arrive,
	output logic             depart,
	output logic             jam_q
);
	zarc_pkg::zarc_state_e st_q;
	zarc_pkg::zarc_state_e st_d;
	logic        sens_q;
	logic        acc_q;
	logic        hold_q;
	logic        arm_q;
	logic        pend_q;
	logic        wait_q;
	logic [31:0] tmr_q;
	logic        cancel;
	logic        rel_new;
	logic        go;
	logic        both_clr;
	logic        both_keep;

	// edges and decisions
	assign arrive    = sensor & ~sens_q;
	assign depart    = ~sensor & sens_q;
	assign cancel    = acc_q & ~acc_hold;
	assign rel_new   = rel_we & (rel_val != rel_cnt_q);
	assign go        = ds_clear & ~wait_q & (~hold_q | pend_q);
	assign both_clr  = (set_trk1 == zarc_pkg::TRK_CLEAR) & (set_trk2 == zarc_pkg::TRK_CLEAR);
	assign both_keep = (set_trk1 == zarc_pkg::TRK_KEEP) & (set_trk2 == zarc_pkg::TRK_KEEP);
	assign motor_run = (st_q == zarc_pkg::ZS_DISCH) | ((st_q == zarc_pkg::ZS_EMPTY) & wake);
	assign ready     = (st_q == zarc_pkg::ZS_EMPTY) & ~wait_q;

	// zone sequence
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			zarc_pkg::ZS_EMPTY: if (arrive) st_d = zarc_pkg::ZS_HELD;
			zarc_pkg::ZS_HELD:  if (depart) st_d = zarc_pkg::ZS_EMPTY;
			                    else if (go) st_d = zarc_pkg::ZS_DISCH;
			zarc_pkg::ZS_DISCH: if (depart) st_d = zarc_pkg::ZS_EMPTY;
			default:            st_d = zarc_pkg::ZS_EMPTY;
		endcase
	end

	// hold, pending release and next-arrival arming
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			st_q <= zarc_pkg::ZS_EMPTY;
			sens_q <= 1'b0;
			acc_q <= 1'b0;
			hold_q <= 1'b0;
			arm_q <= 1'b0;
			pend_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			sens_q <= sensor;
			acc_q <= acc_hold;
			if (cancel)
				hold_q <= 1'b0;
			else if (arrive & (st_q == zarc_pkg::ZS_EMPTY))
				hold_q <= acc_hold | arm_q;
			if (rel_new)
				arm_q <= 1'b1;
			else if (cancel | (arrive & (st_q == zarc_pkg::ZS_EMPTY)))
				arm_q <= 1'b0;
			if (rel_new & (st_q == zarc_pkg::ZS_HELD))
				pend_q <= 1'b1;
			else if (st_q != zarc_pkg::ZS_HELD)
				pend_q <= 1'b0;
		end
	end

	// counters and tracking; arrival loads incoming words
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			arr_cnt_q <= zarc_pkg::REG_RESET;
			dep_cnt_q <= zarc_pkg::REG_RESET;
			rel_cnt_q <= zarc_pkg::REG_RESET;
			trk1_q <= zarc_pkg::REG_RESET;
			trk2_q <= zarc_pkg::REG_RESET;
		end
		else
		begin
			if (arrive)
				arr_cnt_q <= arr_cnt_q + 16'h0001;
			if (depart)
				dep_cnt_q <= arr_cnt_q;
			if (rel_new)
				rel_cnt_q <= rel_val;
			if (arrive & (st_q == zarc_pkg::ZS_EMPTY))
			begin
				trk1_q <= in_trk1;
				trk2_q <= in_trk2;
			end
			else if (rel_new & ~both_keep)
			begin
				trk1_q <= both_clr ? zarc_pkg::REG_RESET : set_trk1;
				trk2_q <= both_clr ? zarc_pkg::REG_RESET : set_trk2;
			end
		end
	end

	// confirmation wait and jam timer; departure wins over confirm
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			wait_q <= 1'b0;
			tmr_q <= 32'h0000_0000;
			jam_q <= 1'b0;
		end
		else
		begin
			if (depart & (st_q == zarc_pkg::ZS_DISCH))
				wait_q <= 1'b1;
			else if (confirm)
				wait_q <= 1'b0;
			tmr_q <= wait_q ? tmr_q + 32'h0000_0001 : 32'h0000_0000;
			if (wait_q & (tmr_q == JAM_CYC - 1))
				jam_q <= 1'b1;
			else if (confirm)
				jam_q <= 1'b0;
		end
	end

	a_depart_equal: assert property (@(posedge sys_clk) disable iff (!rst_b)
		depart |=> (dep_cnt_q == arr_cnt_q)) else $error("departure count not equal");
	a_arrive_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
		arrive |=> (arr_cnt_q == $past(arr_cnt_q) + 16'h0001)) else $error("arrival not counted");
	a_hold_stops: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(st_q == zarc_pkg::ZS_HELD) & hold_q & ~pend_q & ~depart
		|=> (st_q == zarc_pkg::ZS_HELD) & ~motor_run) else $error("held carton moving");
	a_cancel_frees: assert property (@(posedge sys_clk) disable iff (!rst_b)
		cancel & ~arrive |=> ~hold_q & ~arm_q) else $error("cancel did not free");
	a_wait_confirm: assert property (@(posedge sys_clk) disable iff (!rst_b)
		depart & (st_q == zarc_pkg::ZS_DISCH) |=> wait_q & ~ready) else $error("no confirm wait");
endmodule // zarc_zone
`default_nettype wire

// File: logic/zarc_top.sv
/*
 * two-zone controller top: avalon-mm register slave, induct handshake,
 * interrupt status and the two zone instances.
 * assumes field inputs are synchronous to sys_clk; 16-bit registers.
 */
`timescale 1ns/1ns
`default_nettype none
module zarc_top #(
	parameter int unsigned JAM_CYC = zarc_pkg::JAM_CYCLES
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// field sensors
	input  wire logic        up_sensor,
	input  wire logic        dn_sensor,
	input  wire logic        discharge_clear,
	input  wire logic        discharge_confirm,
	// motors
	output logic             up_motor_run,
	output logic             dn_motor_run,
	// interrupt
	output logic             irq
);
	// ------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------
	logic        ack_q;
	logic [31:0] rdata_q;
	logic        req;
	logic        wr_ok;
	logic [15:0] wd;

	// one wait state on every access keeps read data registered
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata    = rdata_q;
	// partial writes to the low half are ignored
	assign wr_ok           = avs_write & ack_q & (avs_byteenable[1:0] == 2'b11);
	assign wd              = avs_writedata[15:0];

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	logic hit_up_acc;
	logic hit_up_rel;
	logic hit_up_s1;
	logic hit_up_s2;
	logic hit_dn_acc;
	logic hit_dn_rel;
	logic hit_dn_s1;
	logic hit_dn_s2;
	logic hit_ind;
	logic hit_it1;
	logic hit_it2;
	logic hit_clr;
	logic hit_en;

	assign hit_up_acc = avs_address == (zarc_pkg::UP_BASE + zarc_pkg::OFS_ACC);
	assign hit_up_rel = avs_address == (zarc_pkg::UP_BASE + zarc_pkg::OFS_REL);
	assign hit_up_s1  = avs_address == (zarc_pkg::UP_BASE + zarc_pkg::OFS_STRK1);
	assign hit_up_s2  = avs_address == (zarc_pkg::UP_BASE + zarc_pkg::OFS_STRK2);
	assign hit_dn_acc = avs_address == (zarc_pkg::DN_BASE + zarc_pkg::OFS_ACC);
	assign hit_dn_rel = avs_address == (zarc_pkg::DN_BASE + zarc_pkg::OFS_REL);
	assign hit_dn_s1  = avs_address == (zarc_pkg::DN_BASE + zarc_pkg::OFS_STRK1);
	assign hit_dn_s2  = avs_address == (zarc_pkg::DN_BASE + zarc_pkg::OFS_STRK2);
	assign hit_ind    = avs_address == zarc_pkg::ADR_IND_STAT;
	assign hit_it1    = avs_address == zarc_pkg::ADR_IND_TRK1;
	assign hit_it2    = avs_address == zarc_pkg::ADR_IND_TRK2;
	assign hit_clr    = avs_address == zarc_pkg::ADR_IRQ_CLR;
	assign hit_en     = avs_address == zarc_pkg::ADR_IRQ_EN;

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	logic [15:0] up_acc_q;
	logic [15:0] dn_acc_q;
	logic [15:0] up_s1_q;
	logic [15:0] up_s2_q;
	logic [15:0] dn_s1_q;
	logic [15:0] dn_s2_q;
	logic [15:0] ind_stat_q;
	logic [15:0] ind_t1_q;
	logic [15:0] ind_t2_q;
	logic        up_cancel;
	logic        dn_cancel;

	// a cancelling write also drops staged tracking words
	assign up_cancel = wr_ok & hit_up_acc & up_acc_q[zarc_pkg::ACC_HOLD_BIT]
		& ~wd[zarc_pkg::ACC_HOLD_BIT];
	assign dn_cancel = wr_ok & hit_dn_acc & dn_acc_q[zarc_pkg::ACC_HOLD_BIT]
		& ~wd[zarc_pkg::ACC_HOLD_BIT];

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			up_acc_q <= zarc_pkg::REG_RESET;
			dn_acc_q <= zarc_pkg::REG_RESET;
			up_s1_q <= zarc_pkg::REG_RESET;
			up_s2_q <= zarc_pkg::REG_RESET;
			dn_s1_q <= zarc_pkg::REG_RESET;
			dn_s2_q <= zarc_pkg::REG_RESET;
		end
		else
		begin
			if (wr_ok & hit_up_acc) up_acc_q <= wd;
			if (wr_ok & hit_dn_acc) dn_acc_q <= wd;
			if (up_cancel)
			begin
				up_s1_q <= zarc_pkg::REG_RESET;
				up_s2_q <= zarc_pkg::REG_RESET;
			end
			else
			begin
				if (wr_ok & hit_up_s1) up_s1_q <= wd;
				if (wr_ok & hit_up_s2) up_s2_q <= wd;
			end
			if (dn_cancel)
			begin
				dn_s1_q <= zarc_pkg::REG_RESET;
				dn_s2_q <= zarc_pkg::REG_RESET;
			end
			else
			begin
				if (wr_ok & hit_dn_s1) dn_s1_q <= wd;
				if (wr_ok & hit_dn_s2) dn_s2_q <= wd;
			end
		end
	end

	// ------------------------------------------------------------
	// induct handshake
	// ------------------------------------------------------------
	logic        ind_ok_q;
	logic        up_arrive;
	logic        up_depart;
	logic        ind_to_one;
	logic        ind_take;
	logic        long_evt;
	logic [15:0] up_in1;
	logic [15:0] up_in2;

	assign ind_to_one = wr_ok & hit_ind & (ind_stat_q == zarc_pkg::IND_RUN)
		& (wd == zarc_pkg::IND_VALID);
	assign ind_take   = up_arrive & ind_ok_q;
	// status still four at the sensor: carton spans more than a zone
	assign long_evt   = up_arrive & (ind_stat_q == zarc_pkg::IND_RUN);
	assign up_in1     = ind_take ? ind_t1_q : zarc_pkg::REG_RESET;
	assign up_in2     = ind_take ? ind_t2_q : zarc_pkg::REG_RESET;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			ind_stat_q <= zarc_pkg::REG_RESET;
			ind_t1_q <= zarc_pkg::REG_RESET;
			ind_t2_q <= zarc_pkg::REG_RESET;
			ind_ok_q <= 1'b0;
		end
		else
		begin
			if (wr_ok & hit_ind) ind_stat_q <= wd;
			if (wr_ok & hit_it1) ind_t1_q <= wd;
			if (wr_ok & hit_it2) ind_t2_q <= wd;
			if (ind_to_one)
				ind_ok_q <= 1'b1;
			else if (ind_take)
				ind_ok_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// zones
	// ------------------------------------------------------------
	logic        dn_ready;
	logic        dn_arrive;
	logic        dn_depart;
	logic        up_jam;
	logic        dn_jam;
	logic [15:0] up_arr;
	logic [15:0] up_dep;
	logic [15:0] up_rel;
	logic [15:0] up_t1;
	logic [15:0] up_t2;
	logic [15:0] dn_arr;
	logic [15:0] dn_dep;
	logic [15:0] dn_rel;
	logic [15:0] dn_t1;
	logic [15:0] dn_t2;
	logic        up_wake;

	assign up_wake = ind_stat_q == zarc_pkg::IND_RUN;

	zarc_zone #(.JAM_CYC(JAM_CYC)) u_up (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.sensor    (up_sensor),
		.ds_clear  (dn_ready),
		.wake      (up_wake),
		.confirm   (dn_arrive),
		.motor_run (up_motor_run),
		.ready     (),
		.acc_hold  (up_acc_q[zarc_pkg::ACC_HOLD_BIT]),
		.rel_we    (wr_ok & hit_up_rel),
		.rel_val   (wd),
		.set_trk1  (up_s1_q),
		.set_trk2  (up_s2_q),
		.in_trk1   (up_in1),
		.in_trk2   (up_in2),
		.arr_cnt_q (up_arr),
		.dep_cnt_q (up_dep),
		.rel_cnt_q (up_rel),
		.trk1_q    (up_t1),
		.trk2_q    (up_t2),
		.arrive    (up_arrive),
		.depart    (up_depart),
		.jam_q     (up_jam)
	);

	// downstream zone: same logic, own registers, fed by upstream
	zarc_zone #(.JAM_CYC(JAM_CYC)) u_dn (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.sensor    (dn_sensor),
		.ds_clear  (discharge_clear),
		.wake      (up_motor_run),
		.confirm   (discharge_confirm),
		.motor_run (dn_motor_run),
		.ready     (dn_ready),
		.acc_hold  (dn_acc_q[zarc_pkg::ACC_HOLD_BIT]),
		.rel_we    (wr_ok & hit_dn_rel),
		.rel_val   (wd),
		.set_trk1  (dn_s1_q),
		.set_trk2  (dn_s2_q),
		.in_trk1   (up_t1),
		.in_trk2   (up_t2),
		.arr_cnt_q (dn_arr),
		.dep_cnt_q (dn_dep),
		.rel_cnt_q (dn_rel),
		.trk1_q    (dn_t1),
		.trk2_q    (dn_t2),
		.arrive    (dn_arrive),
		.depart    (dn_depart),
		.jam_q     (dn_jam)
	);

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	logic [6:0] irq_stat_q;
	logic [6:0] irq_en_q;
	logic [6:0] irq_set;
	logic [6:0] irq_clr;

	assign irq_set = {long_evt, dn_jam, up_jam, dn_depart, dn_arrive, up_depart, up_arrive};
	assign irq_clr = (wr_ok & hit_clr) ? wd[6:0] : 7'h00;
	assign irq     = |(irq_stat_q & irq_en_q);

	// a set arriving with its clear is kept
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			irq_stat_q <= 7'h00;
			irq_en_q <= 7'h00;
		end
		else
		begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			if (wr_ok & hit_en) irq_en_q <= wd[6:0];
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [15:0] rd_up;
	logic [15:0] rd_dn;
	logic [15:0] rd_gl;
	logic [7:0]  ofs;

	assign ofs   = {2'b00, avs_address[5:0]};
	assign rd_up = (ofs == zarc_pkg::OFS_ACC)     ? up_acc_q :
	               (ofs == zarc_pkg::OFS_REL)     ? up_rel :
	               (ofs == zarc_pkg::OFS_REL_CUR) ? up_rel :
	               (ofs == zarc_pkg::OFS_ARR)     ? up_arr :
	               (ofs == zarc_pkg::OFS_DEP)     ? up_dep :
	               (ofs == zarc_pkg::OFS_STRK1)   ? up_s1_q :
	               (ofs == zarc_pkg::OFS_STRK2)   ? up_s2_q :
	               (ofs == zarc_pkg::OFS_CTRK1)   ? up_t1 :
	               (ofs == zarc_pkg::OFS_CTRK2)   ? up_t2 : 16'h0000;
	assign rd_dn = (ofs == zarc_pkg::OFS_ACC)     ? dn_acc_q :
	               (ofs == zarc_pkg::OFS_REL)     ? dn_rel :
	               (ofs == zarc_pkg::OFS_REL_CUR) ? dn_rel :
	               (ofs == zarc_pkg::OFS_ARR)     ? dn_arr :
	               (ofs == zarc_pkg::OFS_DEP)     ? dn_dep :
	               (ofs == zarc_pkg::OFS_STRK1)   ? dn_s1_q :
	               (ofs == zarc_pkg::OFS_STRK2)   ? dn_s2_q :
	               (ofs == zarc_pkg::OFS_CTRK1)   ? dn_t1 :
	               (ofs == zarc_pkg::OFS_CTRK2)   ? dn_t2 : 16'h0000;
	assign rd_gl = hit_ind ? ind_stat_q :
	               hit_it1 ? ind_t1_q :
	               hit_it2 ? ind_t2_q :
	               (avs_address == zarc_pkg::ADR_IRQ_STAT) ? {9'h000, irq_stat_q} :
	               hit_en  ? {9'h000, irq_en_q} : 16'h0000;

	// data captured in the request's first cycle, shown with the ack
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			rdata_q <= 32'h0000_0000;
		else if (avs_read & ~ack_q)
			rdata_q <= {16'h0000, (avs_address[7:6] == 2'b00) ? rd_up :
			            (avs_address[7:6] == 2'b01) ? rd_dn :
			            (avs_address[7:6] == 2'b10) ? rd_gl : 16'h0000};
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_release_detect: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_ok & hit_up_rel & (wd != up_rel) |=> (up_rel == $past(wd)))
		else $error("release value not taken");
	a_induct_valid: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ind_to_one & ~up_arrive |=> ind_ok_q) else $error("induct words not armed");
	a_induct_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
		ind_take & (u_up.st_q == zarc_pkg::ZS_EMPTY)
		|=> (up_t1 == $past(ind_t1_q)) & (up_t2 == $past(ind_t2_q)))
		else $error("induct words not captured");
	a_long_carton: assert property (@(posedge sys_clk) disable iff (!rst_b)
		long_evt |=> irq_stat_q[zarc_pkg::IRQ_LONG]) else $error("long carton missed");
	a_wake_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(up_wake) & ~up_sensor & ~up_motor_run |-> ##[0:2] up_motor_run | up_sensor)
		else $error("wake did not run zone");
	a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_b)
		irq_set[zarc_pkg::IRQ_UP_ARR] & irq_en_q[zarc_pkg::IRQ_UP_ARR] ##1 1'b1 |-> irq)
		else $error("interrupt not raised");
endmodule // zarc_top
`default_nettype wire

// File: test/zarc_plc_model.sv
/*
 * controller model: avalon-mm master that notes each expected read.
 * assumes a slave that holds waitrequest high until it answers.
 */
`timescale 1ns/1ns
`default_nettype none
module zarc_plc_model (
	// clock
	input  wire logic        sys_clk,
	// avalon-mm master
	output logic [7:0]       avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata,
	output logic [3:0]       avs_byteenable,
	input  wire logic        avs_waitrequest
);
	// expected read data, with the address it belongs to
	logic [15:0] exp_q[$];
	logic [7:0]  adr_q[$];
	// idle bus from time zero
	initial
	begin
		avs_address    = 8'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0000_0000;
		avs_byteenable = 4'hF;
	end
	// waitrequest is sampled at the rising edge; nothing moves until it is low
	task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d);
		@(posedge sys_clk);
		avs_address   <= a;
		avs_read      <= ~w;
		avs_write     <= w;
		avs_writedata <= {16'h0000, d};
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge sys_clk);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		adr_q.push_back(a);
		xfer(a, 1'b0, 16'h0000);
	endtask
endmodule // zarc_plc_model
`default_nettype wire

// File: test/test_zone_accumulate_release_ctrl.sv
/*
 * bench for the two-zone accumulate and release controller.
 * assumes zarc_pkg and zarc_top are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module test_zone_accumulate_release_ctrl;
	logic sys_clk, rst_b, up_sensor, dn_sensor, discharge_clear, discharge_confirm;
	logic [7:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest, up_motor_run, dn_motor_run, irq;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic [15:0] tr1, tr2;
	int          seed, miscompares, check_count;
	localparam logic [7:0] UP = zarc_pkg::UP_BASE;
	localparam logic [7:0] DN = zarc_pkg::DN_BASE;
	// jam count shortened so the jam path fits in the run
	zarc_top #(.JAM_CYC(50)) zarc_top_i (.sys_clk(sys_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.up_sensor(up_sensor), .dn_sensor(dn_sensor), .discharge_clear(discharge_clear),
		.discharge_confirm(discharge_confirm), .up_motor_run(up_motor_run),
		.dn_motor_run(dn_motor_run), .irq(irq));
	zarc_plc_model zarc_plc_model_i (.sys_clk(sys_clk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest));
	// 125 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// read monitor: oldest note against the answer, at the edge it is taken
	always @(posedge sys_clk)
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
		begin
			check_count++;
			if (avs_readdata !== {16'h0000, zarc_plc_model_i.exp_q[0]})
			begin
				$display("CHECK FAILED reg %h exp %h got %h", zarc_plc_model_i.adr_q[0],
					zarc_plc_model_i.exp_q[0], avs_readdata);
				miscompares++;
			end
			void'(zarc_plc_model_i.exp_q.pop_front());
			void'(zarc_plc_model_i.adr_q.pop_front());
		end
	task automatic chk(input string n, input logic e, input logic g);
		check_count++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s exp %b got %b", n, e, g);
			miscompares++;
		end
	endtask
	// bounded wait for a motor; a hang shows up as a failed compare
	task automatic wait_run(input logic dn);
		int i;
		i = 0;
		while ((dn ? dn_motor_run : up_motor_run) !== 1'b1 && i < 40)
		begin
			@(negedge sys_clk);
			i++;
		end
		chk("motor run", 1'b1, dn ? dn_motor_run : up_motor_run);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// watchdog
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		test_done();
	end
	// main sequence
	initial
	begin
		{rst_b, up_sensor, dn_sensor, discharge_clear, discharge_confirm} = 5'b00000;
		miscompares = 0;
		check_count = 0;
		seed = 81;
		tr1 = {1'b0, 15'($random(seed))} | 16'h0001;
		tr2 = {1'b0, 15'($random(seed))} | 16'h0001;
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		zarc_plc_model_i.rd(UP + zarc_pkg::OFS_ARR, 16'h0000);
		zarc_plc_model_i.rd(8'hFC, 16'h0000);
		zarc_plc_model_i.wr(zarc_pkg::ADR_IRQ_EN, 16'h007F);
		zarc_plc_model_i.wr(UP + zarc_pkg::OFS_ACC, 16'h0001);
		@(posedge sys_clk) up_sensor <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("up held", 1'b0, up_motor_run);
		zarc_plc_model_i.rd(UP + zarc_pkg::OFS_ARR, 16'h0001);
		zarc_plc_model_i.rd(UP + zarc_pkg::OFS_DEP, 16'h0000);
		zarc_plc_model_i.rd(UP + zarc_pkg::OFS_CTRK1, 16'h0000);
		chk("irq set", 1'b1, irq);
		zarc_plc_model_i.wr(zarc_pkg::ADR_IRQ_CLR, 16'h007F);
		@(negedge sys_clk);
		chk("irq clear", 1'b0, irq);
		// release with fresh tracking: count read, plus one, written back
		zarc_plc_model_i.wr(UP + zarc_pkg::OFS_STRK1, tr1);
		zarc_plc_model_i.wr(UP + zarc_pkg::OFS_STRK2, tr2);
		zarc_plc_model_i.rd(UP + zarc_pkg::OFS_REL_CUR, 16'h0000);
		zarc_plc_model_i.wr(UP + zarc_pkg::OFS_REL, 16'h0001);
		zarc_plc_model_i.rd(UP + zarc_pkg::OFS_REL_CUR, 16'h0001);
		wait_run(1'b0);
		@(posedge sys_clk) up_sensor <= 1'b0;
		zarc_plc_model_i.rd(UP + zarc_pkg::OFS_DEP, 16'h0001);
		@(posedge sys_clk) dn_sensor <= 1'b1;
		repeat (3) @(posedge sys_clk);
		zarc_plc_model_i.rd(DN + zarc_pkg::OFS_CTRK1, tr1);
		zarc_plc_model_i.rd(DN + zarc_pkg::OFS_CTRK2, tr2);
		// downstream full at release time: release must wait, then fire
		zarc_plc_model_i.wr(DN + zarc_pkg::OFS_ACC, 16'h0001);
		zarc_plc_model_i.wr(DN + zarc_pkg::OFS_REL, 16'h0001);
		repeat (4) @(posedge sys_clk);
		chk("dn waits", 1'b0, dn_motor_run);
		@(posedge sys_clk) discharge_clear <= 1'b1;
		wait_run(1'b1);
		@(posedge sys_clk) dn_sensor <= 1'b0;
		repeat (60) @(posedge sys_clk);
		zarc_plc_model_i.rd(zarc_pkg::ADR_IRQ_STAT, 16'h002E);
		@(posedge sys_clk) discharge_confirm <= 1'b1;
		@(posedge sys_clk) discharge_confirm <= 1'b0;
		zarc_plc_model_i.wr(zarc_pkg::ADR_IRQ_CLR, 16'h007F);
		// induct handshake with tracking words
		zarc_plc_model_i.wr(zarc_pkg::ADR_IND_STAT, zarc_pkg::IND_RUN);
		wait_run(1'b0);
		zarc_plc_model_i.wr(zarc_pkg::ADR_IND_TRK1, tr2);
		zarc_plc_model_i.wr(zarc_pkg::ADR_IND_TRK2, tr1);
		zarc_plc_model_i.wr(zarc_pkg::ADR_IND_STAT, zarc_pkg::IND_VALID);
		@(posedge sys_clk) up_sensor <= 1'b1;
		repeat (3) @(posedge sys_clk);
		zarc_plc_model_i.rd(UP + zarc_pkg::OFS_CTRK1, tr2);
		zarc_plc_model_i.rd(UP + zarc_pkg::OFS_CTRK2, tr1);
		// cancel hold: carton goes, pending tracking is dropped
		zarc_plc_model_i.wr(UP + zarc_pkg::OFS_STRK1, 16'h0005);
		zarc_plc_model_i.wr(UP + zarc_pkg::OFS_ACC, 16'h0000);
		wait_run(1'b0);
		zarc_plc_model_i.rd(UP + zarc_pkg::OFS_STRK1, 16'h0000);
		@(posedge sys_clk) up_sensor <= 1'b0;
		@(posedge sys_clk) dn_sensor <= 1'b1;
		repeat (3) @(posedge sys_clk);
		zarc_plc_model_i.rd(DN + zarc_pkg::OFS_CTRK1, tr2);
		// both staged words all-ones clear the tracking at release
		zarc_plc_model_i.wr(DN + zarc_pkg::OFS_STRK1, zarc_pkg::TRK_CLEAR);
		zarc_plc_model_i.wr(DN + zarc_pkg::OFS_STRK2, zarc_pkg::TRK_CLEAR);
		zarc_plc_model_i.wr(DN + zarc_pkg::OFS_REL, 16'h0002);
		zarc_plc_model_i.rd(DN + zarc_pkg::OFS_CTRK1, 16'h0000);
		// status still four at arrival marks a long carton
		zarc_plc_model_i.wr(zarc_pkg::ADR_IRQ_EN, 16'h0040);
		zarc_plc_model_i.wr(zarc_pkg::ADR_IND_STAT, zarc_pkg::IND_RUN);
		chk("long idle", 1'b0, irq);
		@(posedge sys_clk) up_sensor <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("long irq", 1'b1, irq);
		test_done();
	end
endmodule // test_zone_accumulate_release_ctrl
`default_nettype wire
